//--- rtl/sac_defines.vh
// Purpose: Constants for the converter control block
// Assumes: Included by the register bank and the conversion sequencer
// Notes: Byte offsets, one word apart, on a 32-bit classic Wishbone bus
`ifndef SAC_DEFINES_VH
`define SAC_DEFINES_VH

// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define SAC_OFS_LOW 8'h00
`define SAC_OFS_HIGH 8'h04
`define SAC_OFS_CTRL_A 8'h08
`define SAC_OFS_CTRL_B 8'h0c
`define SAC_OFS_INSEL 8'h10

// -----------------------------------------------------------------
// Control A fields
// -----------------------------------------------------------------
`define SAC_A_EN 7
`define SAC_A_SC 6
`define SAC_A_ATE 5
`define SAC_A_IF 4
`define SAC_A_IE 3
`define SAC_A_PS_HI 2
`define SAC_A_PS_LO 0

// -----------------------------------------------------------------
// Input select fields
// -----------------------------------------------------------------
`define SAC_I_REF_HI 7
`define SAC_I_REF_LO 6
`define SAC_I_LAR 5
`define SAC_I_CH_HI 4
`define SAC_I_CH_LO 0

// -----------------------------------------------------------------
// Control B fields and trigger codes
// -----------------------------------------------------------------
`define SAC_B_TS_HI 2
`define SAC_B_TS_LO 0
`define SAC_TS_FREE 3'h0

// -----------------------------------------------------------------
// Reset values and timing in converter clock cycles
// -----------------------------------------------------------------
`define SAC_RST_BYTE 8'h00
`define SAC_CYC_NORMAL 5'd13
`define SAC_CYC_FIRST 5'd25
`define SAC_SH_NORMAL 5'd1
`define SAC_SH_FIRST 5'd13
`define SAC_SH_AUTO 5'd2
`define SAC_SYNC_STAGES 3

`endif

//--- rtl/sac_sar_core.v
// Purpose: Successive approximation sequencer for one conversion
// Assumes: step_i is a one-cycle converter clock enable
// Notes: One result bit per step, most significant bit first
`timescale 1ns/1ps
`default_nettype none
`include "sac_defines.vh"

module sac_sar_core #(
   parameter WIDTH = 10
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire start_i,
   input wire step_i,
   input wire abort_i,
   input wire first_i,
   input wire auto_i,
   input wire cmp_i,
   output wire busy_o,
   output reg sample_o,
   output reg [WIDTH-1:0] dac_o,
   output reg done_o,
   output reg [WIDTH-1:0] code_o
);

   // -----------------------------------------------------------------
   // Step counter and trial code
   // -----------------------------------------------------------------
   reg [4:0] cnt;
   reg [4:0] len;
   reg [4:0] sh_at;
   reg run;
   reg [WIDTH-1:0] trial;
   reg [WIDTH-1:0] bitp;
   wire [WIDTH-1:0] next_trial;

   assign busy_o = run;
   // Trial code with this step's comparator decision folded in
   assign next_trial = trial | (cmp_i ? bitp : {WIDTH{1'b0}});

   // Counts converter clocks; bits resolved after sample-and-hold
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt <= 5'd0;
         len <= 5'd0;
         sh_at <= 5'd0;
         run <= 1'b0;
         trial <= {WIDTH{1'b0}};
         bitp <= {WIDTH{1'b0}};
         sample_o <= 1'b0;
         dac_o <= {WIDTH{1'b0}};
         done_o <= 1'b0;
         code_o <= {WIDTH{1'b0}};
      end else begin
         done_o <= 1'b0;
         sample_o <= 1'b0;
         if (abort_i) begin
            // Converter switched off: drop the conversion in flight
            run <= 1'b0;
         end else if (start_i && !run) begin
            run <= 1'b1;
            cnt <= 5'd0;
            len <= first_i ? `SAC_CYC_FIRST : `SAC_CYC_NORMAL;
            sh_at <= first_i ? `SAC_SH_FIRST :
               (auto_i ? `SAC_SH_AUTO : `SAC_SH_NORMAL);
            trial <= {WIDTH{1'b0}};
            bitp <= {WIDTH{1'b0}};
         end else if (run && step_i) begin
            cnt <= cnt + 5'd1;
            if (cnt == sh_at) begin
               sample_o <= 1'b1;
               bitp <= {1'b1, {(WIDTH-1){1'b0}}};
               dac_o <= {1'b1, {(WIDTH-1){1'b0}}};
            end else if (bitp != {WIDTH{1'b0}}) begin
               // Keep or drop the trial bit, then try the next lower
               trial <= next_trial;
               dac_o <= next_trial | (bitp >> 1);
               bitp <= bitp >> 1;
            end
            if (cnt == len - 5'd1) begin
               run <= 1'b0;
               done_o <= 1'b1;
               // The last decision may fall on the final step
               code_o <= next_trial;
            end
         end
      end
   end

endmodule // sac_sar_core
`default_nettype wire

//--- rtl/sac_ctrl.v
// Purpose: Digital control of a 10-bit successive approximation converter
// Assumes: Classic Wishbone slave, inputs synchronous to clk_i
// Notes: Analog array gives one comparator decision per step
`timescale 1ns/1ps
`default_nettype none
`include "sac_defines.vh"

module sac_ctrl #(
   parameter WIDTH = 10,
   parameter NTRIG = 8
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire [NTRIG-1:0] trigger_i,
   input wire cmp_i,
   output wire analog_enable_o,
   output wire [1:0] reference_select_o,
   output wire [4:0] channel_gain_select_o,
   output wire sample_o,
   output wire [WIDTH-1:0] dac_o,
   output wire irq_o
);

   // -----------------------------------------------------------------
   // Register state
   // -----------------------------------------------------------------
   reg converter_enable;
   reg start_conversion;
   reg auto_trigger_enable;
   reg conversion_complete_flag;
   reg irq_enable;
   reg [2:0] prescale_sel;
   reg [2:0] trigger_source_select;
   reg left_adjust_result;
   reg [1:0] ref_temp;
   reg [4:0] chan_temp;
   reg [1:0] ref_live;
   reg [4:0] chan_live;
   reg [WIDTH-1:0] result;
   reg lock;
   reg first_pending;
   reg [7:0] pcnt;
   reg [NTRIG-1:0] trig_s1;
   reg [NTRIG-1:0] trig_s2;
   reg [NTRIG-1:0] trig_d;
   reg start_pulse;
   reg auto_start;
   reg [7:0] result_high_byte;
   reg [7:0] result_low_byte;

   wire core_busy;
   wire core_done;
   wire [WIDTH-1:0] core_code;
   wire step;
   wire req;
   wire wr_a;
   wire wr_b;
   wire wr_i;
   wire rd_low;
   wire rd_high;
   wire [NTRIG-1:0] trig_rise;
   wire sel_rise;
   wire [7:0] pdiv;
   wire [15:0] just;
   wire free_run;

   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------
   // A request is taken once; the ack cycle blocks a second take
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_a = req && wb_we_i && wb_sel_i[0]
      && (wb_adr_i == `SAC_OFS_CTRL_A);
   assign wr_b = req && wb_we_i && wb_sel_i[0]
      && (wb_adr_i == `SAC_OFS_CTRL_B);
   assign wr_i = req && wb_we_i && wb_sel_i[0]
      && (wb_adr_i == `SAC_OFS_INSEL);
   assign rd_low = req && !wb_we_i && (wb_adr_i == `SAC_OFS_LOW);
   assign rd_high = req && !wb_we_i && (wb_adr_i == `SAC_OFS_HIGH);

   // Acknowledge every access one cycle after the strobe
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // Read mux; unmapped offsets read as zero
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wb_dat_o <= 32'h00000000;
      end else if (req && !wb_we_i) begin
         case (wb_adr_i)
            `SAC_OFS_LOW: wb_dat_o <= {24'h000000, result_low_byte};
            `SAC_OFS_HIGH: wb_dat_o <= {24'h000000, result_high_byte};
            `SAC_OFS_CTRL_A: wb_dat_o <= {24'h000000, converter_enable,
               start_conversion, auto_trigger_enable,
               conversion_complete_flag, irq_enable, prescale_sel};
            `SAC_OFS_CTRL_B: wb_dat_o <= {29'h00000000,
               trigger_source_select};
            `SAC_OFS_INSEL: wb_dat_o <= {24'h000000, ref_temp,
               left_adjust_result, chan_temp};
            default: wb_dat_o <= 32'h00000000;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Converter clock prescaler
   // -----------------------------------------------------------------
   assign pdiv = (8'h01 << prescale_sel);
   assign step = converter_enable && (pcnt == pdiv - 8'h01);

   // Held in reset while disabled and on an auto-trigger event
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pcnt <= 8'h00;
      end else if (!converter_enable || auto_start) begin
         pcnt <= 8'h00;
      end else if (step) begin
         pcnt <= 8'h00;
      end else begin
         pcnt <= pcnt + 8'h01;
      end
   end

   // -----------------------------------------------------------------
   // Trigger synchronisation and edge detect
   // -----------------------------------------------------------------
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         trig_s1 <= {NTRIG{1'b0}};
         trig_s2 <= {NTRIG{1'b0}};
         trig_d <= {NTRIG{1'b0}};
      end else begin
         trig_s1 <= trigger_i;
         trig_s2 <= trig_s1;
         trig_d <= trig_s2;
      end
   end

   // Per-source rising edge
   genvar g;
   generate
      for (g = 0; g < NTRIG; g = g + 1) begin : g_rise
         assign trig_rise[g] = trig_s2[g] && !trig_d[g];
      end
   endgenerate

   // Source zero is this block's own completion, others external flags
   assign sel_rise = (trigger_source_select == `SAC_TS_FREE) ?
      core_done : trig_rise[trigger_source_select];

   // Own completion as trigger keeps the start bit high between runs
   assign free_run = auto_trigger_enable
      && (trigger_source_select == `SAC_TS_FREE);

   // -----------------------------------------------------------------
   // Start requests
   // -----------------------------------------------------------------
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         auto_start <= 1'b0;
         start_pulse <= 1'b0;
      end else begin
         // Edges while busy are dropped; a level never retriggers
         auto_start <= converter_enable && auto_trigger_enable && sel_rise
            && (!core_busy || core_done);
         start_pulse <= start_conversion && converter_enable
            && !core_busy && !core_done && step;
      end
   end

   // -----------------------------------------------------------------
   // Control registers, start bit and completion flag
   // -----------------------------------------------------------------
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         converter_enable <= 1'b0;
         start_conversion <= 1'b0;
         auto_trigger_enable <= 1'b0;
         conversion_complete_flag <= 1'b0;
         irq_enable <= 1'b0;
         prescale_sel <= 3'h0;
         trigger_source_select <= 3'h0;
         left_adjust_result <= 1'b0;
         ref_temp <= 2'h0;
         chan_temp <= 5'h00;
         first_pending <= 1'b1;
      end else begin
         if (wr_a) begin
            converter_enable <= wb_dat_i[`SAC_A_EN];
            auto_trigger_enable <= wb_dat_i[`SAC_A_ATE];
            irq_enable <= wb_dat_i[`SAC_A_IE];
            prescale_sel <= wb_dat_i[`SAC_A_PS_HI:`SAC_A_PS_LO];
            if (wb_dat_i[`SAC_A_EN] && !converter_enable) begin
               first_pending <= 1'b1;
            end
         end
         if (wr_b) begin
            trigger_source_select <= wb_dat_i[`SAC_B_TS_HI:`SAC_B_TS_LO];
         end
         if (wr_i) begin
            ref_temp <= wb_dat_i[`SAC_I_REF_HI:`SAC_I_REF_LO];
            left_adjust_result <= wb_dat_i[`SAC_I_LAR];
            chan_temp <= wb_dat_i[`SAC_I_CH_HI:`SAC_I_CH_LO];
         end
         // Start bit: set by write or auto start, cleared at completion unless free running
         if (!converter_enable) begin
            start_conversion <= 1'b0;
         end else if (core_done && !auto_start && !free_run) begin
            // Single conversions end here; free running keeps it set
            start_conversion <= 1'b0;
         end else if (auto_start) begin
            start_conversion <= 1'b1;
         end else if (wr_a && wb_dat_i[`SAC_A_SC]) begin
            start_conversion <= 1'b1;
         end
         // The long first conversion is spent once the core runs
         if (core_busy) begin
            first_pending <= 1'b0;
         end
         // Completion sets the flag even if result dropped; set wins
         if (core_done) begin
            conversion_complete_flag <= 1'b1;
         end else if (wr_a && wb_dat_i[`SAC_A_IF]) begin
            conversion_complete_flag <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Live selections: follow temp unless converting or disabled
   // -----------------------------------------------------------------
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ref_live <= 2'h0;
         chan_live <= 5'h00;
      end else if (converter_enable && (!core_busy || core_done)) begin
         ref_live <= ref_temp;
         chan_live <= chan_temp;
      end
   end

   assign analog_enable_o = converter_enable;
   assign reference_select_o = ref_live;
   assign channel_gain_select_o = chan_live;
   assign irq_o = conversion_complete_flag && irq_enable;

   // -----------------------------------------------------------------
   // Result store with low-then-high lock
   // -----------------------------------------------------------------
   assign just = left_adjust_result ?
      {core_code, 6'h00} : {6'h00, core_code};

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         result <= {WIDTH{1'b0}};
         result_high_byte <= `SAC_RST_BYTE;
         result_low_byte <= `SAC_RST_BYTE;
         lock <= 1'b0;
      end else begin
         if (rd_high) begin
            lock <= 1'b0;
         end else if (rd_low) begin
            lock <= 1'b1;
         end
         // A completion inside the low-then-high window is dropped
         if (core_done && !lock && !rd_low) begin
            result <= core_code;
            result_high_byte <= just[15:8];
            result_low_byte <= just[7:0];
         end else if (wr_i && !lock) begin
            // Re-justify stored code when the adjust bit changes
            result_high_byte <= wb_dat_i[`SAC_I_LAR] ?
               result[9:2] : {6'h00, result[9:8]};
            result_low_byte <= wb_dat_i[`SAC_I_LAR] ?
               {result[1:0], 6'h00} : result[7:0];
         end
      end
   end

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   // Switching the converter off abandons a conversion in flight
   sac_sar_core #(
      .WIDTH(WIDTH)
   ) u_core (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .start_i(start_pulse || auto_start),
      .step_i(step),
      .abort_i(!converter_enable),
      .first_i(first_pending),
      .auto_i(auto_start),
      .cmp_i(cmp_i),
      .busy_o(core_busy),
      .sample_o(sample_o),
      .dac_o(dac_o),
      .done_o(core_done),
      .code_o(core_code)
   );

endmodule // sac_ctrl
`default_nettype wire

//--- test/sac_ctrl_chk.sv
// Purpose: Port checker for the converter control block
// Assumes: Bound to sac_ctrl, one clock domain
// Notes: Spacing figures hold for every prescale setting
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_chk (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic analog_enable_o,
   input wire logic [1:0] reference_select_o,
   input wire logic [4:0] channel_gain_select_o,
   input wire logic sample_o,
   input wire logic irq_o
);
default clocking cb @(posedge clk_i);
endclocking
default disable iff (!rst_n_i);
// ---------------------------------------------------------------
// Bus handshake
// ---------------------------------------------------------------
ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
   else $error("ack held longer than one cycle");
ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
   else $error("ack missing one cycle after request");
ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
   else $error("ack without request");
dat_top_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
   else $error("read data upper bits not zero");
// ---------------------------------------------------------------
// Selection locking and sampling
// ---------------------------------------------------------------
sel_lock_a: assert property (
   sample_o |=> $stable(channel_gain_select_o) [*8])
   else $error("channel changed during conversion");
ref_lock_a: assert property (
   sample_o |=> $stable(reference_select_o) [*8])
   else $error("reference changed during conversion");
sel_off_a: assert property (
   !analog_enable_o [*3] |-> $stable(channel_gain_select_o))
   else $error("channel applied while disabled");
samp_off_a: assert property (sample_o |-> analog_enable_o)
   else $error("sample while converter off");
samp_gap_a: assert property (sample_o |=> !sample_o [*8])
   else $error("samples closer than a conversion");
samp_c: cover property (sample_o);
irq_c: cover property ($rose(irq_o));
lock_c: cover property (sample_o ##1 !sample_o [*8]);
endmodule // sac_ctrl_chk
bind sac_ctrl sac_ctrl_chk i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .analog_enable_o(analog_enable_o),
   .reference_select_o(reference_select_o),
   .channel_gain_select_o(channel_gain_select_o),
   .sample_o(sample_o), .irq_o(irq_o));
`default_nettype wire

//--- test/sac_analog_model.sv
// Purpose: Behavioural analog array for the converter bench
// Assumes: vin_i is the ideal input code, held at each sample pulse
// Notes: Output is scrambled while the converter is off
`timescale 1ns/1ps
`default_nettype none
module sac_analog_model #(
   parameter SLOW = 0
) (
   input wire logic clk_i,
   input wire logic enable_i,
   input wire logic sample_i,
   input wire logic [9:0] dac_i,
   input wire logic [9:0] vin_i,
   output logic cmp_o
);
logic [9:0] held = 10'h000;
logic last = 1'b0;
logic slow_q = 1'b0;
logic fast;
// Sample and hold, ground is code zero
always @(posedge clk_i) begin
   if (sample_i) begin
      held <= vin_i;
   end
   last <= cmp_o;
   slow_q <= fast;
end
// One decision per trial; the hold tracks the input while sampling
assign fast = (sample_i ? vin_i : held) >= dac_i;
assign cmp_o = !enable_i ? !last : (SLOW != 0) ? slow_q : fast;
endmodule // sac_analog_model
`default_nettype wire

//--- test/sac_ctrl_test.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Prescale 0, trigger source 1 driven by the bench
// Notes: Sample pulses are counted to judge conversion starts
`timescale 1ns/1ps
`default_nettype none
`include "sac_defines.vh"
module sac_ctrl_test;
logic clk_i = 1'b0;
logic rst_n_i = 1'b0;
logic cyc = 1'b0;
logic we = 1'b0;
logic [7:0] adr = 8'h00;
logic [31:0] wdat = 32'h00000000;
logic [31:0] rdat;
logic ack, cmp, en, samp, irq;
logic [7:0] trig = 8'h00;
logic [1:0] refsel;
logic [4:0] chsel;
logic [9:0] dac;
logic [9:0] vin = 10'h000;
logic [7:0] q;
int n_errors = 0;
int tests_run = 0;
int n_samp = 0;
// Clock and sample counter
always #2 clk_i = ~clk_i;
always @(posedge clk_i) if (samp === 1'b1) n_samp <= n_samp + 1;
sac_ctrl i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
   .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
   .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .trigger_i(trig),
   .cmp_i(cmp), .analog_enable_o(en), .reference_select_o(refsel),
   .channel_gain_select_o(chsel), .sample_o(samp), .dac_o(dac),
   .irq_o(irq));
sac_analog_model i_ana (.clk_i(clk_i), .enable_i(en), .sample_i(samp),
   .dac_i(dac), .vin_i(vin), .cmp_o(cmp));
task automatic complete_run;
   if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
   end else begin
      $display("RESULT: FAIL");
   end
   $finish;
endtask
task automatic chk(input string nm, input logic [9:0] e, logic [9:0] g);
   tests_run++;
   if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
   end
endtask
// One classic cycle, held until ack
task automatic bus(input logic w, input logic [7:0] a, logic [7:0] d);
   cyc <= 1'b1;
   we <= w;
   adr <= a;
   wdat <= {24'h000000, d};
   @(posedge clk_i);
   while (ack !== 1'b1) @(posedge clk_i);
   q = rdat[7:0];
   cyc <= 1'b0;
   we <= 1'b0;
   @(posedge clk_i);
endtask
task automatic wait_done;
   q = 8'h40;
   while (q[6] !== 1'b0) bus(1'b0, `SAC_OFS_CTRL_A, 8'h00);
endtask
task automatic t_reset;
   for (int i = 0; i < 6; i++) begin
      bus(1'b0, 8'(i * 4), 8'h00);
      chk("reset_reg", 10'h000, 10'(q));
   end
   bus(1'b1, 8'h14, 8'hff);
   bus(1'b0, 8'h14, 8'h00);
   chk("unmapped", 10'h000, 10'(q));
endtask
task automatic t_sel;
   bus(1'b1, `SAC_OFS_INSEL, 8'h1f);
   repeat (2) @(posedge clk_i);
   chk("chan_off", 10'h000, 10'(chsel));
   chk("enable_off", 10'h000, 10'(en));
   bus(1'b1, `SAC_OFS_CTRL_A, 8'h80);
   chk("enable_on", 10'h001, 10'(en));
   for (int i = 0; i < 32; i++) begin
      bus(1'b1, `SAC_OFS_INSEL, {i[1:0], 1'b0, i[4:0]});
      repeat (2) @(posedge clk_i);
      chk("ref", 10'(i[1:0]), 10'(refsel));
      chk("chan", 10'(i[4:0]), 10'(chsel));
   end
endtask
task automatic t_conv(input logic [9:0] v, input logic adj);
   vin <= v;
   bus(1'b1, `SAC_OFS_INSEL, {2'b01, adj, 5'h03});
   bus(1'b1, `SAC_OFS_CTRL_A, 8'hc8);
   bus(1'b0, `SAC_OFS_CTRL_A, 8'h00);
   chk("busy", 10'h001, 10'(q[6]));
   wait_done;
   chk("flag", 10'h001, 10'(q[4]));
   chk("irq", 10'h001, 10'(irq));
   bus(1'b0, `SAC_OFS_LOW, 8'h00);
   chk("low", adj ? 10'({v[1:0], 6'h00}) : 10'(v[7:0]), 10'(q));
   bus(1'b0, `SAC_OFS_HIGH, 8'h00);
   chk("high", adj ? 10'(v[9:2]) : 10'(v[9:8]), 10'(q));
   bus(1'b1, `SAC_OFS_CTRL_A, 8'h90);
endtask
task automatic t_lock;
   t_conv(10'h155, 1'b0);
   bus(1'b0, `SAC_OFS_LOW, 8'h00);
   vin <= 10'h0aa;
   bus(1'b1, `SAC_OFS_CTRL_A, 8'hc0);
   bus(1'b1, `SAC_OFS_INSEL, 8'h45);
   chk("chan_hold", 10'h003, 10'(chsel));
   wait_done;
   chk("flag_lost", 10'h001, 10'(q[4]));
   chk("chan_new", 10'h005, 10'(chsel));
   bus(1'b0, `SAC_OFS_HIGH, 8'h00);
   chk("high_kept", 10'h001, 10'(q));
   bus(1'b0, `SAC_OFS_LOW, 8'h00);
   chk("low_kept", 10'h055, 10'(q));
   bus(1'b0, `SAC_OFS_HIGH, 8'h00);
endtask
task automatic t_trig;
   int n0;
   bus(1'b1, `SAC_OFS_CTRL_B, 8'h00);
   n0 = n_samp;
   bus(1'b1, `SAC_OFS_CTRL_A, 8'he0);
   repeat (100) @(posedge clk_i);
   chk("free_run", 10'h001, 10'(n_samp - n0 >= 5));
   bus(1'b0, `SAC_OFS_CTRL_A, 8'h00);
   chk("busy_auto", 10'h001, 10'(q[6]));
   bus(1'b1, `SAC_OFS_CTRL_A, 8'h00);
   bus(1'b1, `SAC_OFS_CTRL_B, 8'h01);
   bus(1'b1, `SAC_OFS_CTRL_A, 8'ha0);
   n0 = n_samp;
   trig[1] <= 1'b1;
   repeat (20) @(posedge clk_i);
   trig[1] <= 1'b0;
   @(posedge clk_i);
   trig[1] <= 1'b1;
   repeat (200) @(posedge clk_i);
   chk("trig_once", 10'h001, 10'(n_samp - n0));
   trig[1] <= 1'b0;
   @(posedge clk_i);
   trig[1] <= 1'b1;
   repeat (100) @(posedge clk_i);
   chk("trig_again", 10'h002, 10'(n_samp - n0));
   bus(1'b0, `SAC_OFS_LOW, 8'h00);
   chk("auto_low", 10'h0aa, 10'(q));
   bus(1'b0, `SAC_OFS_HIGH, 8'h00);
   chk("auto_high", 10'h000, 10'(q));
   bus(1'b1, `SAC_OFS_CTRL_A, 8'he0);
   repeat (100) @(posedge clk_i);
   chk("start_auto", 10'h003, 10'(n_samp - n0));
   bus(1'b1, `SAC_OFS_CTRL_A, 8'h00);
endtask
// Main sequence
initial begin
   repeat (16) @(posedge clk_i);
   rst_n_i <= 1'b1;
   @(posedge clk_i);
   t_reset;
   t_sel;
   t_conv(10'h000, 1'b0);
   t_conv(10'h3ff, 1'b1);
   t_conv(10'h2a5, 1'b0);
   t_conv(10'h2a5, 1'b1);
   t_lock;
   t_trig;
   complete_run;
end
// Watchdog
initial begin
   #40000;
   n_errors++;
   complete_run;
end
endmodule // sac_ctrl_test
`default_nettype wire
